/* pkg/scs_defs.vh */
// Constants for the system clock select block
// Function
// - Four sources: three main-input kinds, on-chip oscillator
// - Only mode and oscillator registers pick clock
// - On-chip source, divided by 8/4/2/1
// - Main input source, divided by 8/4/2/1
// - Divider code zero passes source undivided
// - Instruction clock is system clock divided by three
// - One instruction clock equals one machine cycle
// - After reset run on-chip source divided by eight
`ifndef SCS_DEFS_VH
`define SCS_DEFS_VH
`define SCS_ADDR_MODE 4'h0
`define SCS_ADDR_OSC 4'h4
`define SCS_ADDR_STAT 4'h8
`define SCS_ADDR_MCYC 4'hc
`define SCS_MODE_SRC 0
`define SCS_MODE_M1 1
`define SCS_MODE_DIVLO 2
`define SCS_MODE_DIVHI 3
`define SCS_OSC_CTRL0 0
`define SCS_OSC_KIND_LO 1
`define SCS_OSC_KIND_HI 2
`define SCS_MODE_RST 4'hd
`define SCS_OSC_RST 3'h0
`define SCS_KIND_CERAMIC 2'h0
`define SCS_KIND_RC 2'h1
`define SCS_KIND_EXT 2'h2
`define SCS_SRC_MAIN 1'b0
`define SCS_SRC_RING 1'b1
`define SCS_INSTR_DIV 3
`define SCS_INSTR_LAST 2'h2
`endif

/* design/scs_tick_div.v */
// Divide a stream of enable pulses by a run-time ratio
`timescale 1ns/10ps
`default_nettype none
module scs_tick_div #(
  parameter CW = 3
) (
  input wire clk_sys,
  input wire rst_n,
  input wire clear,
  input wire tick_in,
  input wire [CW-1:0] last,
  output reg tick_out
);
  reg [CW-1:0] cnt_r;

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= {CW{1'b0}};
      tick_out <= 1'b0;
    end else if (clear) begin
      cnt_r <= {CW{1'b0}};
      tick_out <= 1'b0;
    end else if (tick_in) begin
      if (cnt_r >= last) begin
        cnt_r <= {CW{1'b0}};
        tick_out <= 1'b1;
      end else begin
        cnt_r <= cnt_r + {{(CW-1){1'b0}}, 1'b1};
        tick_out <= 1'b0;
      end
    end else begin
      tick_out <= 1'b0;
    end
  end
endmodule // scs_tick_div
`default_nettype wire

/* design/scs_clock_select.v */
// System clock source select, divider and instruction clock
`timescale 1ns/10ps
`default_nettype none
`include "scs_defs.vh"
module scs_clock_select #(
  parameter MCW = 16
) (
  input wire clk_sys,
  input wire rst_n,
  input wire xin_in,
  input wire ring_in,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [3:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  output wire system_clk_tick,
  output wire instr_clk_tick,
  output reg system_clk_r,
  output reg src_ring_r
);
  reg xin_s1_r, xin_s2_r, xin_s3_r;
  reg ring_s1_r, ring_s2_r, ring_s3_r;
  reg [3:0] clock_mode_reg_r;
  reg [2:0] osc_ctrl_reg_r;
  reg [1:0] div_code_r;
  reg [MCW-1:0] mcyc_cnt_r;
  reg sw_clear_r;
  reg [2:0] div_last;
  reg src_tick;
  reg sel_valid;
  reg sel_ring;
  reg [31:0] rd_nxt;
  wire xin_rise;
  wire ring_rise;
  wire bus_req;
  wire wr_en;
  wire sel_change;

  // Pin synchronisers, third stage only for edge detection
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      xin_s1_r <= 1'b0;
      xin_s2_r <= 1'b0;
      xin_s3_r <= 1'b0;
      ring_s1_r <= 1'b0;
      ring_s2_r <= 1'b0;
      ring_s3_r <= 1'b0;
    end else begin
      xin_s1_r <= xin_in;
      xin_s2_r <= xin_s1_r;
      xin_s3_r <= xin_s2_r;
      ring_s1_r <= ring_in;
      ring_s2_r <= ring_s1_r;
      ring_s3_r <= ring_s2_r;
    end
  end

  assign xin_rise = xin_s2_r & ~xin_s3_r;
  assign ring_rise = ring_s2_r & ~ring_s3_r;

  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_en = bus_req & wb_we_i & wb_sel_i[0];

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      clock_mode_reg_r <= `SCS_MODE_RST;
      osc_ctrl_reg_r <= `SCS_OSC_RST;
    end else if (wr_en) begin
      if (wb_adr_i == `SCS_ADDR_MODE) begin
        clock_mode_reg_r <= wb_dat_i[3:0];
      end
      if (wb_adr_i == `SCS_ADDR_OSC) begin
        osc_ctrl_reg_r <= wb_dat_i[2:0];
      end
    end
  end

  // Decode selection from the two registers
  always @* begin
    sel_valid = 1'b0;
    sel_ring = src_ring_r;
    // On-chip source, mode bit one ignored
    if (clock_mode_reg_r[`SCS_MODE_SRC] && !osc_ctrl_reg_r[`SCS_OSC_CTRL0]) begin
      sel_valid = 1'b1;
      sel_ring = `SCS_SRC_RING;
    end else if (!clock_mode_reg_r[`SCS_MODE_SRC] && !clock_mode_reg_r[`SCS_MODE_M1]) begin
      sel_valid = 1'b1;
      sel_ring = `SCS_SRC_MAIN;
    end
  end

  assign sel_change = sel_valid &&
    ((sel_ring != src_ring_r) ||
     (clock_mode_reg_r[`SCS_MODE_DIVHI:`SCS_MODE_DIVLO] != div_code_r));

  // Reset starts on-chip divided by eight
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      src_ring_r <= `SCS_SRC_RING;
      div_code_r <= 2'h3;
      sw_clear_r <= 1'b0;
    end else begin
      sw_clear_r <= sel_change;
      if (sel_valid) begin
        src_ring_r <= sel_ring;
        div_code_r <= clock_mode_reg_r[`SCS_MODE_DIVHI:`SCS_MODE_DIVLO];
      end
    end
  end

  always @* begin
    src_tick = src_ring_r ? ring_rise : xin_rise;
    case (div_code_r)
      2'h3: div_last = 3'h7;
      2'h2: div_last = 3'h3;
      2'h1: div_last = 3'h1;
      2'h0: div_last = 3'h0;
      default: div_last = 3'h7;
    endcase
  end

  scs_tick_div #(
    .CW(3)
  ) u_sys_div (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .clear(sw_clear_r),
    .tick_in(src_tick),
    .last(div_last),
    .tick_out(system_clk_tick)
  );

  scs_tick_div #(
    .CW(2)
  ) u_instr_div (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .clear(sw_clear_r),
    .tick_in(system_clk_tick),
    .last(`SCS_INSTR_LAST),
    .tick_out(instr_clk_tick)
  );

  // Square-wave system clock and machine cycle count
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      system_clk_r <= 1'b0;
      mcyc_cnt_r <= {MCW{1'b0}};
    end else begin
      if (system_clk_tick) begin
        system_clk_r <= ~system_clk_r;
      end
      if (instr_clk_tick) begin
        mcyc_cnt_r <= mcyc_cnt_r + {{(MCW-1){1'b0}}, 1'b1};
      end
    end
  end

  // Read mux, unmapped reads zero
  always @* begin
    rd_nxt = 32'h0;
    case (wb_adr_i)
      `SCS_ADDR_MODE: rd_nxt[3:0] = clock_mode_reg_r;
      `SCS_ADDR_OSC: rd_nxt[2:0] = osc_ctrl_reg_r;
      `SCS_ADDR_STAT: rd_nxt[3:0] = {div_code_r, sel_valid, src_ring_r};
      `SCS_ADDR_MCYC: rd_nxt[MCW-1:0] = mcyc_cnt_r;
      default: rd_nxt = 32'h0;
    endcase
  end

  // Wishbone answer one cycle after request
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= bus_req;
      if (bus_req && !wb_we_i) begin
        wb_dat_o <= rd_nxt;
      end
    end
  end
endmodule // scs_clock_select
`default_nettype wire

/* bench/scs_clock_select_props.sv */
// Clock select checker
`timescale 1ns/10ps
`default_nettype none
module scs_clock_select_props (
  input wire clk_sys,
  input wire rst_n,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_ack_o,
  input wire system_clk_tick,
  input wire instr_clk_tick,
  input wire system_clk_r,
  input wire src_ring_r
);
  logic [2:0] quiet_r;
  logic src_q_r;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // Cycles since the active source last switched
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      quiet_r <= 3'h0;
      src_q_r <= 1'b1;
    end else begin
      src_q_r <= src_ring_r;
      if (src_ring_r != src_q_r) begin
        quiet_r <= 3'h0;
      end else if (quiet_r != 3'h7) begin
        quiet_r <= quiet_r + 3'h1;
      end
    end
  end
  chk_ack_take: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
  chk_ack_one: assert property (wb_ack_o |=> !wb_ack_o) else $error("long ack");
  chk_tick_gap: assert property (system_clk_tick && quiet_r > 3'h2 |->
    !$past(system_clk_tick) && !$past(system_clk_tick, 2) && !$past(system_clk_tick, 3)) else $error("tick");
  chk_clk_edge: assert property ($changed(system_clk_r) == $past(system_clk_tick)) else $error("clk");
  chk_instr_src: assert property (instr_clk_tick |-> $past(system_clk_tick)) else $error("instr");
  chk_instr_gap: assert property (instr_clk_tick |=> !instr_clk_tick [*8]) else $error("gap");
  chk_reset_ring: assert property ($rose(rst_n) |-> src_ring_r && !system_clk_r) else $error("reset");
  chk_src_write: assert property ($changed(src_ring_r) |-> wb_ack_o || $past(wb_ack_o)
    || $past(wb_ack_o, 2) || $past(wb_ack_o, 3)) else $error("src");
  cover property (instr_clk_tick);
  cover property (wb_ack_o && !src_ring_r);
  cover property (system_clk_tick && !src_ring_r);
endmodule // scs_clock_select_props
bind scs_clock_select scs_clock_select_props i_props (.*);
`default_nettype wire

/* bench/scs_clock_select_test.sv */
// Self-checking bench for the clock select block
`timescale 1ns/10ps
`default_nettype none
module scs_clock_select_test;
  logic clk_sys = 0, rst_n = 0, xin_in = 0, ring_in = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, run = 1;
  logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0, r, rq[$];
  wire [31:0] wb_dat_o;
  wire wb_ack_o, system_clk_tick, instr_clk_tick, system_clk_r, src_ring_r;
  int pq[$], failures = 0, checks_done = 0, ph = 0, n = 0, have = 0, i, seed = 32'h67ee;
  int sc = 0, skip = 0, ic = 0;
  bit sq[$], sw = 0;
  scs_clock_select i_dut (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .xin_in(xin_in),
    .ring_in(ring_in),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .system_clk_tick(system_clk_tick),
    .instr_clk_tick(instr_clk_tick),
    .system_clk_r(system_clk_r),
    .src_ring_r(src_ring_r)
  );
  initial forever #25 clk_sys = ~clk_sys;
  // Ring period 4 clk, main input 6 clk; run low freezes both
  always @(posedge clk_sys) begin
    ph <= ph + run;
    ring_in <= ph % 4 < 2;
    xin_in <= ph % 6 < 3;
  end
  task tally(input bit ok, input string what);
    checks_done++;
    if (!ok) begin
      failures++;
      $display("CHECK FAILED %0t %s", $time, what);
    end
  endtask
  task cmp_read(input [31:0] g, input [31:0] e);
    tally(g === e, $sformatf("read %h want %h", g, e));
  endtask
  task cmp_count(input [31:0] g, input [31:0] e);
    tally(g === e, $sformatf("count %0d want %0d", g, e));
  endtask
  task cmp_level(input logic g, input logic e);
    tally(g === e, $sformatf("level %b want %b", g, e));
  endtask
  always @(posedge clk_sys) begin
    n++;
    if (wb_ack_o === 1'b1 && !wb_we_i) cmp_read(wb_dat_o, rq.pop_front());
    // A selection write restarts both dividers: skip the cut intervals
    if (wb_ack_o === 1'b1 && wb_we_i) skip = 2;
    if (instr_clk_tick === 1'b1) begin
      ic++;
      if (skip == 0) cmp_count(sc, 3);
      else skip--;
      sc = 0;
    end
    if (system_clk_tick === 1'b1) begin
      cmp_level(system_clk_r, sw);
      sw = !sw;
      sc++;
      if (have && pq.size()) begin
        cmp_count(n, pq.pop_front());
        cmp_level(src_ring_r, sq.pop_front());
      end
      have = !have && pq.size() > 0;
      n = 0;
    end
  end
  task bus(input [3:0] a, input w, input [31:0] d);
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    if (!w) rq.push_back(d);
    do @(posedge clk_sys); while (wb_ack_o !== 1'b1);
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
    @(posedge clk_sys);
  endtask
  task per(input int e, input bit s);
    repeat (100) @(posedge clk_sys);
    pq.push_back(e);
    sq.push_back(s);
    repeat (300) if (pq.size()) @(posedge clk_sys);
    if (pq.size()) begin
      tally(1'b0, "no system clock period");
      pq.delete();
      sq.delete();
    end
  endtask
  task report_and_stop;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #1000000;
    failures++;
    report_and_stop;
  end
  initial begin
    repeat (2) @(posedge clk_sys);
    rst_n <= 1;
    bus(4'h0, 0, 32'hd);
    bus(4'h4, 0, 32'h0);
    per(32, 1);
    for (i = 0; i < 8; i++) begin
      bus(4'h0, 1, (i & 3) << 2 | i >> 2);
      per((i > 3 ? 4 : 6) << (i & 3), i > 3);
    end
    bus(4'h0, 1, 32'h2);
    bus(4'h8, 0, 32'hd);
    bus(4'h0, 1, 32'hb);
    per(16, 1);
    bus(4'h4, 1, 32'h1);
    bus(4'h0, 1, 32'h4);
    per(12, 0);
    bus(4'h8, 0, 32'h6);
    r = $random(seed) & 32'h6;
    bus(4'h4, 1, r);
    bus(4'h4, 0, r);
    bus(4'h2, 0, 32'h0);
    run <= 0;
    repeat (20) @(posedge clk_sys);
    bus(4'hc, 0, ic);
    report_and_stop;
  end
endmodule // scs_clock_select_test
`default_nettype wire
